// ---- logic/ppw_pkg.sv ----
// Shared constants and types of the per-clock pulse width modulator
package ppw_pkg;
    localparam int SUB_BITS = 5;
    localparam logic [5:0] SUB_COUNT = 6'h20;
    localparam logic [4:0] PHASE_LAST = 5'h1F;
    localparam logic [4:0] PHASE_FIRST = 5'h00;
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hFF;
    localparam logic [8:0] WIDTH_ROUND = 9'h004;
    localparam int WIDTH_SHIFT = 3;
    localparam logic [4:0] CAL_DIV_LAST = 5'h1F;
    localparam logic [5:0] CAL_STEP_LAST = 6'h3F;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    localparam int CAL_BOUND_CYC = 32 * 64;

    typedef struct packed {
        logic [7:0] code;
        logic single_edge;
        logic side;
    } ppw_word_t;

    localparam ppw_word_t WORD_IDLE = '{code: 8'h00, single_edge: 1'b0, side: 1'b0};

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_TRIG = 3'b010,
        CAL_RUN = 3'b100
    } ppw_cal_t;
endpackage

// ---- logic/ppw_word_if.sv ----
// Valid/ready carrier for width words between the modulator's modules
`timescale 1ns/1ps
interface ppw_word_if;
    import ppw_pkg::*;
    logic valid;
    logic ready;
    ppw_word_t data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ---- logic/ppw_buf.sv ----
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
module ppw_buf
    import ppw_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    ppw_word_if.dst fill,
    ppw_word_if.src drain
);
    typedef struct packed {
        ppw_word_t [1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } ppw_buf_st_t;

    ppw_buf_st_t st_q;
    ppw_buf_st_t st_d;
    logic push;
    logic pop;

    assign fill.ready = (st_q.count != 2'd2);
    assign drain.valid = (st_q.count != 2'd0);
    assign drain.data = st_q.mem[st_q.rd_ptr];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr_ptr] = fill.data;
            st_d.wr_ptr = ~st_q.wr_ptr;
        end
        if (pop) begin
            st_d.rd_ptr = ~st_q.rd_ptr;
        end
        st_d.count = 2'(st_q.count + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ---- logic/ppw_top.sv ----
// Per-clock pulse width modulator with calibration sequencer
// Functional notes
// - Width code and placement bits are captured on clock edges; controller supplies each period.
// - Inputs pass two register stages plus the output register before their pulse appears.
// - Code zero gives a fully low period regardless of placement.
// - Code 255 gives a fully high period, placement ignored.
// - Width rises monotonically with code, zero to full period.
// - Top code pulse runs slightly past the period end.
// - Pulses meeting at a period boundary stay continuously high.
// - Force-high input holds the output high.
// - Releasing force-high resumes normal pulse generation.
// - Low-power input low shuts nonessential logic; recalibrate afterwards.
// - Calibration done rises within a fixed bound after trigger falls.
// - Ramp trim steps every 32nd clock, 64 steps at most.
// - Trigger held high at least 1 us; calibration starts on fall.
// - Single-edge high: side high right, side low left; else centered.
`timescale 1ns/1ps
module ppw_top
    import ppw_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    // Word stream from the controller
    input wire logic [7:0] width_code,
    input wire logic single_edge_select,
    input wire logic edge_side_select,
    input wire logic in_valid,
    output logic in_ready,
    // Overrides
    input wire logic force_high,
    input wire logic power_reduce_n,
    // Calibration trigger, pulse output and calibration results
    input wire logic cal_start,
    output logic pwm_out,
    output logic cal_done,
    output logic [5:0] ramp_trim
);
    // Whole module state, registered in one place
    typedef struct packed {
        logic [4:0] phase;
        ppw_word_t act;
        // Period just ended held the top code
        logic carry_full;
        logic out;
        ppw_cal_t cal;
        logic [4:0] div;
        logic [5:0] step;
        logic done;
        logic [5:0] trim;
    } ppw_st_t;

    ppw_st_t st_q;
    ppw_st_t st_d;

    ppw_word_if in_w ();
    ppw_word_if act_w ();

    // True on the last subdivision, where the next word is taken
    function automatic logic ppw_period_end(input logic [4:0] ph);
        ppw_period_end = (ph == PHASE_LAST);
    endfunction

    // Number of subdivisions a code covers, rounded to the nearest step
    function automatic logic [5:0] ppw_width_of(input logic [7:0] code);
        logic [8:0] scaled;
        scaled = 9'(code) + WIDTH_ROUND;
        ppw_width_of = 6'(scaled >> WIDTH_SHIFT);
    endfunction

    // First high subdivision of a pulse, per placement mode
    function automatic logic [5:0] ppw_start_of(input ppw_word_t w);
        logic [5:0] width;
        logic [5:0] slack;
        width = ppw_width_of(w.code);
        slack = 6'(SUB_COUNT - width);
        if (!w.single_edge) begin
            ppw_start_of = slack >> 1;
        end else if (w.side) begin
            ppw_start_of = slack;
        end else begin
            ppw_start_of = 6'h00;
        end
    endfunction

    // Decide whether a word's pulse is high at a given subdivision
    function automatic logic ppw_pulse_at(input ppw_word_t w, input logic [4:0] ph);
        logic [5:0] width;
        logic [5:0] start;
        logic [5:0] p;
        width = ppw_width_of(w.code);
        start = ppw_start_of(w);
        p = {1'b0, ph};
        if (w.code == CODE_MIN) begin
            ppw_pulse_at = 1'b0;
        end else if (w.code == CODE_MAX) begin
            ppw_pulse_at = 1'b1;
        end else begin
            // Right-aligned start plus width lands exactly on the period end
            ppw_pulse_at = (p >= start) && (p < 6'(start + width));
        end
    endfunction

    // One decode per subdivision; the output then only picks by phase
    logic [SUB_COUNT-1:0] act_pat;
    generate
        for (genvar i = 0; i < SUB_COUNT; i++) begin : g_pat
            assign act_pat[i] = ppw_pulse_at(st_q.act, 5'(i));
        end
    endgenerate

    // First register stage is the buffer entry
    assign in_w.valid = in_valid;
    assign in_w.data = '{
        code: width_code,
        single_edge: single_edge_select,
        side: edge_side_select
    };
    assign in_ready = in_w.ready;

    // Two-deep queue absorbs a controller that runs ahead of the period
    ppw_buf i_ppw_buf (
        .clock(clock),
        .rstn(rstn),
        .fill(in_w),
        .drain(act_w)
    );

    // Drain once per output period, so the buffer really fills
    assign act_w.ready = ppw_period_end(st_q.phase);

    // The output register adds one clock: the pin shows phase k after
    // the edge that ends phase k, so a period on the pin runs from
    // phase 1 to phase 0 of the following one.
    always_comb begin
        st_d = st_q;
        st_d.phase = 5'(st_q.phase + 5'd1);
        if (ppw_period_end(st_q.phase)) begin
            // Second stage: word active for the coming period
            st_d.act = act_w.valid ? act_w.data : WORD_IDLE;
            st_d.carry_full = (st_q.act.code == CODE_MAX);
        end
        if (force_high) begin
            st_d.out = 1'b1;
        end else begin
            // Overrun into the next period keeps boundaries seamless
            st_d.out = act_pat[st_q.phase]
                       || (st_q.carry_full && st_q.phase == PHASE_FIRST);
        end

        // No analog compare ends the sequence early here, so unless cal_start rises
        // again or power_reduce_n falls it runs every step and the trim settles at its top value.
        unique case (st_q.cal)
            CAL_IDLE: begin
                if (cal_start) begin
                    st_d.cal = CAL_TRIG;
                    st_d.done = 1'b0;
                end
            end
            CAL_TRIG: begin
                if (!cal_start) begin
                    st_d.cal = CAL_RUN;
                    st_d.div = 5'd0;
                    st_d.step = 6'd0;
                    st_d.trim = TRIM_RESET;
                end
            end
            CAL_RUN: begin
                st_d.div = 5'(st_q.div + 5'd1);
                if (cal_start) begin
                    st_d.cal = CAL_TRIG;
                end else if (st_q.div == CAL_DIV_LAST) begin
                    st_d.trim = 6'(st_q.trim + 6'd1);
                    st_d.step = 6'(st_q.step + 6'd1);
                    if (st_q.step == CAL_STEP_LAST) begin
                        st_d.trim = st_q.trim;
                        st_d.done = 1'b1;
                        st_d.cal = CAL_IDLE;
                    end
                end
            end
            default: begin
                st_d.cal = CAL_IDLE;
            end
        endcase

        if (!power_reduce_n) begin
            // Sequencer off; the old trim is no longer trusted
            st_d.cal = CAL_IDLE;
            st_d.done = 1'b0;
            // Calibration counters parked so they stop toggling while power is reduced
            st_d.div = 5'h00;
            st_d.step = 6'h00;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{
                phase: PHASE_FIRST,
                act: WORD_IDLE,
                carry_full: 1'b0,
                out: 1'b0,
                cal: CAL_IDLE,
                div: 5'h00,
                step: 6'h00,
                done: 1'b0,
                trim: TRIM_RESET
            };
        end else begin
            st_q <= st_d;
        end
    end

    assign pwm_out = st_q.out;
    assign cal_done = st_q.done;
    assign ramp_trim = st_q.trim;
endmodule

// ---- test/ppw_checker.sv ----
// Port assertions for the pulse width modulator
`timescale 1ns/1ps
module ppw_checker
    import ppw_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic force_high,
    input wire logic power_reduce_n,
    input wire logic cal_start,
    input wire logic pwm_out,
    input wire logic cal_done,
    input wire logic [5:0] ramp_trim
);
    logic armed_q;
    logic [11:0] cnt_q;
    logic [6:0] idle_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Counts only an armed run, so idle time after reset is not a late finish
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            armed_q <= 1'b0;
            cnt_q <= 12'h000;
            idle_q <= 7'h00;
        end else begin
            armed_q <= cal_start | (armed_q & ~cal_done & power_reduce_n);
            cnt_q <= (armed_q & ~cal_start & ~cal_done & power_reduce_n) ? cnt_q + 12'h001 : 12'h000;
            idle_q <= (in_valid & in_ready) ? 7'h00 : (idle_q == 7'h7F ? idle_q : idle_q + 7'h01);
        end
    end
    a_force_high: assert property (force_high |=> pwm_out) else $error("force ignored");
    a_idle_low: assert property (idle_q == 7'h7F && !force_high && !$past(force_high) |-> !pwm_out)
        else $error("pulse without word");
    a_cal_clear: assert property (cal_start |=> !cal_done) else $error("done during trigger");
    a_cal_hold: assert property (cal_done && !cal_start && power_reduce_n |=> cal_done)
        else $error("done dropped");
    a_power_abort: assert property (!power_reduce_n |=> !cal_done) else $error("done in low power");
    a_trim_full: assert property ($rose(cal_done) |-> ramp_trim == 6'h3F) else $error("trim short");
    a_cal_bound: assert property (cnt_q <= 12'(CAL_BOUND_CYC + 2)) else $error("calibration late");
    a_cal_early: assert property ($rose(cal_done) |-> cnt_q >= 12'h7FF) else $error("done early");
endmodule

bind ppw_top ppw_checker i_ppw_checker (.clock(clock), .rstn(rstn), .in_valid(in_valid),
    .in_ready(in_ready), .force_high(force_high), .power_reduce_n(power_reduce_n),
    .cal_start(cal_start), .pwm_out(pwm_out), .cal_done(cal_done), .ramp_trim(ramp_trim));

// ---- test/ppw_ctrl_model.sv ----
// Controller model offering width words over valid and ready
`timescale 1ns/1ps
module ppw_ctrl_model (
    input wire logic clock,
    input wire logic in_ready,
    output logic [7:0] width_code,
    output logic single_edge_select,
    output logic edge_side_select,
    output logic in_valid
);
    initial begin
        in_valid = 1'b0;
        {width_code, single_edge_select, edge_side_select} = 10'h000;
    end
    // Word held until taken, one word per wanted period
    task automatic send(input logic [9:0] w);
        {width_code, single_edge_select, edge_side_select} <= w;
        in_valid <= 1'b1;
        // Room is judged mid-cycle, where the buffer count has settled
        @(negedge clock);
        while (in_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        in_valid <= 1'b0;
        // Released lines must not look like the old word
        {width_code, single_edge_select, edge_side_select} <= ~w;
        @(posedge clock);
    endtask
endmodule

// ---- test/ppw_top_tb.sv ----
// Self-checking bench for the pulse width modulator
`timescale 1ns/1ps
module ppw_top_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic force_high = 1'b0;
    logic power_reduce_n = 1'b1;
    logic cal_start = 1'b0;
    logic single_edge_select, edge_side_select, in_valid, in_ready, pwm_out, cal_done;
    logic [7:0] width_code;
    logic [5:0] ramp_trim;
    logic [11:0] e;
    int failures = 0;
    int compares = 0;
    int hi, run, n, first, p;
    int tick = 0;
    // Code, single edge, side
    logic [9:0] vec [6] = '{10'h002, 10'h3FC, 10'h3FF, 10'h202, 10'h190, 10'h06F};
    always #5 clock = ~clock;
    // Cycles since reset release, which is also the modulator's phase count
    always @(posedge clock) tick <= rstn ? tick + 1 : 0;
    ppw_top i_ppw_top (.clock(clock), .rstn(rstn), .width_code(width_code),
        .single_edge_select(single_edge_select), .edge_side_select(edge_side_select),
        .in_valid(in_valid), .in_ready(in_ready), .force_high(force_high),
        .power_reduce_n(power_reduce_n), .cal_start(cal_start), .pwm_out(pwm_out),
        .cal_done(cal_done), .ramp_trim(ramp_trim));
    ppw_ctrl_model i_ppw_ctrl_model (.clock(clock), .in_ready(in_ready), .width_code(width_code),
        .single_edge_select(single_edge_select), .edge_side_select(edge_side_select),
        .in_valid(in_valid));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic measure(input int cyc);
        hi = 0;
        run = 0;
        n = 0;
        first = -1;
        repeat (cyc) begin
            // Sampled mid-cycle, where the output has settled
            @(negedge clock);
            n = (pwm_out === 1'b1) ? n + 1 : 0;
            hi += int'(pwm_out === 1'b1);
            run = (n > run) ? n : run;
            if (pwm_out === 1'b1 && first < 0) begin
                first = (tick + 31) % 32;
            end
        end
        @(posedge clock);
    endtask
    // Trigger held 100 cycles (1 us), then the full step sequence
    task automatic calibrate;
        cal_start <= 1'b1;
        repeat (100) @(posedge clock);
        @(negedge clock);
        chk(12'(cal_done), 12'h000);
        @(posedge clock);
        cal_start <= 1'b0;
        n = 0;
        while (cal_done !== 1'b1 && n < 2200) begin
            @(negedge clock);
            n++;
        end
        chk(12'(n >= 2048 && n <= 2052), 12'h001);
        chk(12'(ramp_trim), 12'h03F);
        @(posedge clock);
    endtask
    task automatic test_done;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        foreach (vec[i]) begin
            fork
                i_ppw_ctrl_model.send(vec[i]);
                measure(100);
            join
            e = (({4'h0, vec[i][9:2]} + 12'h004) >> 3) + 12'(vec[i][9:2] == 8'hFF);
            chk(12'(hi), e);
            chk(12'(run), e);
            // First high subdivision expected from the placement bits
            if (vec[i][9:2] == 8'h00) begin
                p = -1;
            end else if (vec[i][9:2] == 8'hFF || vec[i][1:0] == 2'b10) begin
                p = 0;
            end else if (vec[i][1:0] == 2'b11) begin
                p = 32 - int'(e);
            end else begin
                p = (32 - int'(e)) / 2;
            end
            chk(12'(first), 12'(p));
        end
        // Third word is refused until the buffer drains
        fork
            begin
                i_ppw_ctrl_model.send(10'h3FF);
                i_ppw_ctrl_model.send(10'h3FE);
                i_ppw_ctrl_model.send(10'h3FC);
            end
            measure(200);
        join
        chk(12'(run), 12'h061);
        force_high <= 1'b1;
        measure(10);
        chk(12'(hi), 12'h009);
        force_high <= 1'b0;
        // The forced cycle at release plus one left-aligned half-width pulse
        fork
            i_ppw_ctrl_model.send(10'h202);
            measure(100);
        join
        chk(12'(hi), 12'h011);
        // Second run starts with done high, so its clearing is visible
        calibrate();
        calibrate();
        power_reduce_n <= 1'b0;
        repeat (2) @(negedge clock);
        chk(12'(cal_done), 12'h000);
        // Reset during low power, after the second run, returns every output to its idle level
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(negedge clock);
        chk(12'({ramp_trim, in_ready, pwm_out, cal_done}), 12'h004);
        @(posedge clock);
        rstn <= 1'b1;
        power_reduce_n <= 1'b1;
        repeat (2) @(negedge clock);
        chk(12'({ramp_trim, in_ready, pwm_out, cal_done}), 12'h004);
        test_done();
    end
    // About three times the expected run length
    initial begin
        #160000;
        failures++;
        test_done();
    end
endmodule
